//--- verilog/mam_defines.svh
// Register map, alarm codes, blink counts and timing constants of the motion alarm manager
`ifndef MAM_DEFINES_SVH
`define MAM_DEFINES_SVH

`define MAM_ADDR_W          8
`define MAM_REG_ALARM       8'h00
`define MAM_REG_CLEAR       8'h04
`define MAM_REG_INT_STATUS  8'h08
`define MAM_REG_INT_MASK    8'h0C

`define MAM_CLR_CMD_BIT     0
`define MAM_ALM_ACTIVE_BIT  8
`define MAM_ALM_CLRABLE_BIT 9
`define MAM_INT_RAISE_BIT   0
`define MAM_INT_CLEAR_BIT   1
`define MAM_INT_MASK_RST    2'h0

`define MAM_RESP_OKAY       2'h0
`define MAM_RESP_SLVERR     2'h2

`define MAM_CODE_NONE       8'h00
`define MAM_CODE_ESTOP      8'h68
`define MAM_CODE_LS_BOTH    8'h60
`define MAM_CODE_LS_SWAP    8'h61
`define MAM_CODE_HOME       8'h62
`define MAM_CODE_HW_OT      8'h66
`define MAM_CODE_SW_OT      8'h67
`define MAM_CODE_INVALID    8'h70
`define MAM_CODE_SENSOR     8'h42
`define MAM_CODE_ROTOR      8'h43
`define MAM_CODE_NVRAM      8'h41
`define MAM_CODE_SYSTEM     8'hF0
`define MAM_CODE_OVERHEAT   8'h21
`define MAM_CODE_OVERLOAD   8'h30
`define MAM_CODE_OVERSPEED  8'h31
`define MAM_CODE_OVERVOLT   8'h22
`define MAM_CODE_DEVIATION  8'h10
`define MAM_CODE_OVERCURR   8'h20

`define MAM_BLINK_OFF       4'h0
`define MAM_BLINK_HEAT      4'h2
`define MAM_BLINK_VOLT      4'h3
`define MAM_BLINK_DEV       4'h4
`define MAM_BLINK_CURR      4'h5
`define MAM_BLINK_ESTOP     4'h6
`define MAM_BLINK_MOTION    4'h7
`define MAM_BLINK_SENSOR    4'h8
`define MAM_BLINK_NVRAM     4'h9
`define MAM_BLINK_STEADY    4'hF

`define MAM_CLK_HZ          20000000
`define MAM_BLINK_ON_MS     200
`define MAM_BLINK_OFF_MS    200
`define MAM_BLINK_GAP_MS    1000
`define MAM_BLINK_ON_CYC    ((`MAM_CLK_HZ / 1000) * `MAM_BLINK_ON_MS)
`define MAM_BLINK_OFF_CYC   ((`MAM_CLK_HZ / 1000) * `MAM_BLINK_OFF_MS)
`define MAM_BLINK_GAP_CYC   ((`MAM_CLK_HZ / 1000) * `MAM_BLINK_GAP_MS)
`define MAM_PWRUP_CYC       5'h1F

`endif

//--- verilog/mam_pkg.sv
// Types shared by the motion alarm manager modules
package mam_pkg;

  typedef logic [24:0] mam_cnt_t;

  typedef enum logic [1:0] {
    BL_IDLE = 2'b00,
    BL_ON   = 2'b01,
    BL_OFF  = 2'b10,
    BL_GAP  = 2'b11
  } mam_blink_e;

  typedef struct packed {
    mam_blink_e state;
    mam_cnt_t   cnt;
    logic [3:0] done;
    logic       lamp;
  } mam_blink_s;

  typedef struct packed {
    logic        awRdy;
    logic        wRdy;
    logic        awHave;
    logic        wHave;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic        wLow;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arRdy;
    logic        rValid;
    logic [1:0]  rResp;
    logic [31:0] rData;
    logic        aclPrev;
    logic        almActive;
    logic        alarm_clear_command;
    logic [7:0]  almCode;
    logic [3:0]  blinkCnt;
    logic        alarmOut;
    logic        deenergize;
    logic        stopNow;
    logic        decelStop;
    logic        progHalt;
    logic        ioRelease;
    logic        homeReset;
    logic        swLimitOff;
    logic [1:0]  intSts;
    logic [1:0]  intMask;
    logic        irq;
    logic [4:0]  pwrCnt;
  } mam_state_s;

endpackage

//--- verilog/mam_blinker.sv
// Alarm lamp sequencer: N flashes then a pause, or steady light
`timescale 1ns/1ns
`include "mam_defines.svh"
module mam_blinker
  import mam_pkg::*;
#(
  parameter int ON_CYC  = `MAM_BLINK_ON_CYC,
  parameter int OFF_CYC = `MAM_BLINK_OFF_CYC,
  parameter int GAP_CYC = `MAM_BLINK_GAP_CYC
)
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Flash count, zero is dark
  input  wire logic [3:0] blinkCount,
  // Lamp drive
  output logic            lamp
);

  mam_blink_s st;
  mam_blink_s n;
  logic [3:0] doneNext;

  always_comb
  begin
    n = st;
    doneNext = st.done + 4'h1;
    if (blinkCount == `MAM_BLINK_OFF)
    begin
      n.state = BL_IDLE;
      n.lamp = 1'b0;
    end
    else if (blinkCount == `MAM_BLINK_STEADY)
    begin
      n.state = BL_IDLE;
      n.lamp = 1'b1;
    end
    else
    begin
      case (st.state)
        BL_IDLE:
        begin
          n.state = BL_ON;
          n.cnt = mam_cnt_t'(ON_CYC - 1);
          n.done = 4'h0;
          n.lamp = 1'b1;
        end
        BL_ON:
        begin
          n.cnt = st.cnt - mam_cnt_t'(1);
          if (st.cnt == mam_cnt_t'(0))
          begin
            n.lamp = 1'b0;
            n.done = doneNext;
            n.state = (doneNext >= blinkCount) ? BL_GAP : BL_OFF;
            n.cnt = (doneNext >= blinkCount) ? mam_cnt_t'(GAP_CYC - 1) : mam_cnt_t'(OFF_CYC - 1);
          end
        end
        BL_OFF:
        begin
          n.cnt = st.cnt - mam_cnt_t'(1);
          if (st.cnt == mam_cnt_t'(0))
          begin
            n.state = BL_ON;
            n.cnt = mam_cnt_t'(ON_CYC - 1);
            n.lamp = 1'b1;
          end
        end
        default:
        begin
          n.cnt = st.cnt - mam_cnt_t'(1);
          if (st.cnt == mam_cnt_t'(0))
            n.state = BL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      st <= '{state: BL_IDLE, cnt: '0, done: 4'h0, lamp: 1'b0};
    else
      st <= n;
  end

  assign lamp = st.lamp;

endmodule

//--- verilog/motion_alarm_manager.sv
// Alarm latch, stop actions, clear handling and AXI4-Lite access for the motor driver
// Functional notes
// RULE1: Emergency stop latches 68h, six flashes; action select 0 halts program, de-energizes. Code gives seven flashes when action select is 1.
// RULE2: Both limit sensors on together latch 60h, seven-flash group, clearable.
// RULE3: Limit sensors wired swapped latch 61h and stop the motor immediately.
// RULE4: Failed mechanical home seeking latches 62h and stops motion immediately.
// RULE5: Hardware overtravel latches 66h, halts program, stops motor immediately. Code halts program only when emergency_halt_action_select is 1.
// RULE6: Software overtravel latches 67h and decelerates to a stop.
// RULE7: Starting an inexecutable operation pattern latches 70h and stops the motion.
// RULE8: Cable or position-sensor fault latches 42h, eight flashes, de-energizes, power cycle only.
// RULE9: Shaft turning at power-up latches 43h, eight flashes, de-energizes, power cycle only.
// RULE10: Corrupted stored parameters latch 41h, nine flashes, de-energize, power cycle only.
// RULE11: Internal driver failure latches F0h, lamp steady on, de-energizes, power cycle only.
// RULE12: Alarm output is off while any alarm is latched, on again afterwards.
// RULE13: The latched alarm code is readable by the host on query.
// RULE14: A clearable alarm clears on clear input falling edge or host clear command.
// RULE15: Power-cycle clearing needs power removed at least 10 seconds beforehand.
// RULE16: Clearing heat, load, speed, voltage or deviation alarms releases I/O, home, limit.
// RULE17: Sensor, rotor, memory, overcurrent and system alarms ignore input and command clears.
// RULE18: The outside party removes the alarm cause before clearing, else it re-raises.
// RULE19: Codes without their own flash count use their group's count.
`timescale 1ns/1ns
`include "mam_defines.svh"
module motion_alarm_manager
  import mam_pkg::*;
#(
  parameter int BLINK_ON_CYC  = `MAM_BLINK_ON_CYC,
  parameter int BLINK_OFF_CYC = `MAM_BLINK_OFF_CYC,
  parameter int BLINK_GAP_CYC = `MAM_BLINK_GAP_CYC
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Fault detectors
  input  wire logic        emergencyStopInput,
  input  wire logic        forwardLimitSensor,
  input  wire logic        reverseLimitSensor,
  input  wire logic        limitSwapDetected,
  input  wire logic        homeSeekFailed,
  input  wire logic        hwLimitPassed,
  input  wire logic        swLimitPassed,
  input  wire logic        invalidOpStarted,
  input  wire logic        motorSensorFault,
  input  wire logic        shaftTurning,
  input  wire logic        nvParamCorrupt,
  input  wire logic        driverFailure,
  input  wire logic        overheatFault,
  input  wire logic        overloadFault,
  input  wire logic        overspeedFault,
  input  wire logic        overvoltageFault,
  input  wire logic        deviationFault,
  input  wire logic        overcurrentFault,
  // Configuration and clear input
  input  wire logic        emergency_stop_action_select,
  input  wire logic        emergency_halt_action_select,
  input  wire logic        alarmClearInput,
  // Alarm and motor control outputs
  output logic             alarmOutput,
  output logic             alarmIndicatorLamp,
  output logic             motorDeenergize,
  output logic             motorStopNow,
  output logic             motorDecelStop,
  output logic             programHalt,
  output logic             ioAssignRelease,
  output logic             electricalHomeReset,
  output logic             softLimitDisable,
  output logic             irq
);

  mam_state_s st;
  mam_state_s n;
  logic       powerUp;
  logic       lockFault;
  logic [7:0] newCode;
  logic       wrFire;
  logic       rdFire;
  logic       clearCmd;
  logic       clearEdge;
  logic       clearReq;
  logic       doClear;
  logic       raise;

  // Highest severity first so a power-cycle alarm is never masked by a clearable one
  function automatic logic [7:0] faultCode(input logic pu);
    if (driverFailure)                                  return `MAM_CODE_SYSTEM;   // RULE11
    else if (nvParamCorrupt)                            return `MAM_CODE_NVRAM;    // RULE10
    else if (motorSensorFault)                          return `MAM_CODE_SENSOR;   // RULE8
    else if (shaftTurning && pu)                        return `MAM_CODE_ROTOR;    // RULE9
    else if (overcurrentFault)                          return `MAM_CODE_OVERCURR;
    else if (emergencyStopInput)                        return `MAM_CODE_ESTOP;    // RULE1
    else if (overvoltageFault)                          return `MAM_CODE_OVERVOLT;
    else if (deviationFault)                            return `MAM_CODE_DEVIATION;
    else if (overheatFault)                             return `MAM_CODE_OVERHEAT;
    else if (overloadFault)                             return `MAM_CODE_OVERLOAD;
    else if (overspeedFault)                            return `MAM_CODE_OVERSPEED;
    else if (forwardLimitSensor && reverseLimitSensor)  return `MAM_CODE_LS_BOTH;  // RULE2
    else if (limitSwapDetected)                         return `MAM_CODE_LS_SWAP;  // RULE3
    else if (homeSeekFailed)                            return `MAM_CODE_HOME;     // RULE4
    else if (hwLimitPassed)                             return `MAM_CODE_HW_OT;    // RULE5
    else if (swLimitPassed)                             return `MAM_CODE_SW_OT;    // RULE6
    else if (invalidOpStarted)                          return `MAM_CODE_INVALID;  // RULE7
    else                                                return `MAM_CODE_NONE;
  endfunction

  function automatic logic powerCycleOnly(input logic [7:0] c);
    return c == `MAM_CODE_SENSOR || c == `MAM_CODE_ROTOR || c == `MAM_CODE_NVRAM ||
           c == `MAM_CODE_OVERCURR || c == `MAM_CODE_SYSTEM; // RULE17
  endfunction

  function automatic logic clearInits(input logic [7:0] c);
    return c == `MAM_CODE_OVERHEAT || c == `MAM_CODE_OVERLOAD || c == `MAM_CODE_OVERSPEED ||
           c == `MAM_CODE_OVERVOLT || c == `MAM_CODE_DEVIATION; // RULE16
  endfunction

  function automatic logic torqueOff(input logic [7:0] c, input logic sel);
    return clearInits(c) || powerCycleOnly(c) || (c == `MAM_CODE_ESTOP && !sel); // RULE1 RULE8 RULE9 RULE10 RULE11
  endfunction

  function automatic logic [3:0] blinkOf(input logic [7:0] c, input logic sel);
    if (c == `MAM_CODE_SYSTEM)                               return `MAM_BLINK_STEADY; // RULE11
    else if (c == `MAM_CODE_NVRAM)                           return `MAM_BLINK_NVRAM;  // RULE10
    else if (c == `MAM_CODE_SENSOR || c == `MAM_CODE_ROTOR)  return `MAM_BLINK_SENSOR; // RULE8 RULE9
    else if (c == `MAM_CODE_OVERCURR)                        return `MAM_BLINK_CURR;
    else if (c == `MAM_CODE_DEVIATION)                       return `MAM_BLINK_DEV;
    else if (c == `MAM_CODE_OVERVOLT)                        return `MAM_BLINK_VOLT;
    else if (clearInits(c))                                  return `MAM_BLINK_HEAT;
    else if (c == `MAM_CODE_ESTOP && !sel)                   return `MAM_BLINK_ESTOP;  // RULE1
    else if (c == `MAM_CODE_NONE)                            return `MAM_BLINK_OFF;
    else                                                     return `MAM_BLINK_MOTION; // RULE19
  endfunction

  always_comb
  begin
    n = st;
    powerUp = st.pwrCnt != `MAM_PWRUP_CYC;
    newCode = faultCode(powerUp);
    lockFault = powerCycleOnly(newCode);
    wrFire = st.awHave && st.wHave && !st.bValid;
    rdFire = s_axi_arvalid && st.arRdy;
    clearCmd = wrFire && st.awAddr == `MAM_REG_CLEAR && st.wLow && st.wData[`MAM_CLR_CMD_BIT];
    clearEdge = st.aclPrev && !alarmClearInput;
    clearReq = clearCmd || clearEdge;
    doClear = st.almActive && st.alarm_clear_command && clearReq; // RULE14
    // A cleared alarm whose cause persists comes back next cycle
    raise = newCode != `MAM_CODE_NONE && (!st.almActive || (lockFault && st.alarm_clear_command)); // RULE18
    n.aclPrev = alarmClearInput;
    if (powerUp)
      n.pwrCnt = st.pwrCnt + 5'h1;
    n.ioRelease = 1'b0;
    if (doClear)
    begin
      n.almActive = 1'b0;
      n.almCode = `MAM_CODE_NONE;
      n.ioRelease = clearInits(st.almCode); // RULE16
      n.homeReset = n.homeReset | clearInits(st.almCode); // RULE16
      n.swLimitOff = n.swLimitOff | clearInits(st.almCode); // RULE16
    end
    if (raise)
    begin
      n.almActive = 1'b1;
      n.almCode = newCode;
      n.alarm_clear_command = !lockFault; // RULE17
    end
    n.alarmOut = !n.almActive; // RULE12
    n.blinkCnt = blinkOf(n.almCode, emergency_stop_action_select);
    n.deenergize = n.almActive && torqueOff(n.almCode, emergency_stop_action_select);
    n.decelStop = n.almActive && n.almCode == `MAM_CODE_SW_OT; // RULE6
    n.stopNow = n.almActive && !n.deenergize && !n.decelStop && n.almCode != `MAM_CODE_NONE; // RULE3 RULE4 RULE5 RULE7
    n.progHalt = n.almActive && ((n.almCode == `MAM_CODE_ESTOP && !emergency_stop_action_select) ||
                 (n.almCode == `MAM_CODE_HW_OT && emergency_halt_action_select) || clearInits(n.almCode)); // RULE1 RULE5
    if (doClear && clearInits(st.almCode))
      n.progHalt = 1'b1; // RULE16
    // Write channel: address and data accepted independently, answered once both are held
    if (s_axi_awvalid && st.awRdy)
    begin
      n.awHave = 1'b1;
      n.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wRdy)
    begin
      n.wHave = 1'b1;
      n.wData = s_axi_wdata;
      n.wLow = s_axi_wstrb[0];
    end
    if (st.bValid && s_axi_bready)
      n.bValid = 1'b0;
    if (wrFire)
    begin
      n.awHave = 1'b0;
      n.wHave = 1'b0;
      n.bValid = 1'b1;
      n.bResp = `MAM_RESP_OKAY;
      if (st.awAddr == `MAM_REG_INT_MASK)
      begin
        if (st.wLow)
          n.intMask = st.wData[1:0];
      end
      else if (st.awAddr != `MAM_REG_CLEAR)
        n.bResp = `MAM_RESP_SLVERR;
    end
    n.awRdy = !n.awHave && !n.bValid;
    n.wRdy = !n.wHave && !n.bValid;
    // Read channel
    if (st.rValid && s_axi_rready)
      n.rValid = 1'b0;
    n.intSts = st.intSts;
    if (rdFire)
    begin
      n.rValid = 1'b1;
      n.rResp = `MAM_RESP_OKAY;
      n.rData = 32'h0000_0000;
      if (s_axi_araddr == `MAM_REG_ALARM)
      begin
        n.rData[7:0] = st.almCode; // RULE13
        n.rData[`MAM_ALM_ACTIVE_BIT] = st.almActive;
        n.rData[`MAM_ALM_CLRABLE_BIT] = st.alarm_clear_command;
      end
      else if (s_axi_araddr == `MAM_REG_INT_STATUS)
      begin
        n.rData[1:0] = st.intSts;
        n.intSts = 2'h0;
      end
      else if (s_axi_araddr == `MAM_REG_INT_MASK)
        n.rData[1:0] = st.intMask;
      else if (s_axi_araddr != `MAM_REG_CLEAR)
        n.rResp = `MAM_RESP_SLVERR;
    end
    n.arRdy = !n.rValid;
    // Setting after the read clear lets a same-cycle event survive
    if (raise)
      n.intSts[`MAM_INT_RAISE_BIT] = 1'b1;
    if (doClear)
      n.intSts[`MAM_INT_CLEAR_BIT] = 1'b1;
    n.irq = |(n.intSts & n.intMask);
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st <= '0;
      st.alarmOut <= 1'b1;
      st.awRdy <= 1'b1;
      st.wRdy <= 1'b1;
      st.arRdy <= 1'b1;
      st.intMask <= `MAM_INT_MASK_RST;
    end
    else
      st <= n;
  end

  mam_blinker #(
    .ON_CYC  (BLINK_ON_CYC),
    .OFF_CYC (BLINK_OFF_CYC),
    .GAP_CYC (BLINK_GAP_CYC)
  ) u_blinker (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .blinkCount (st.blinkCnt),
    .lamp       (alarmIndicatorLamp)
  );

  assign s_axi_awready = st.awRdy;
  assign s_axi_wready = st.wRdy;
  assign s_axi_bresp = st.bResp;
  assign s_axi_bvalid = st.bValid;
  assign s_axi_arready = st.arRdy;
  assign s_axi_rdata = st.rData;
  assign s_axi_rresp = st.rResp;
  assign s_axi_rvalid = st.rValid;
  assign alarmOutput = st.alarmOut;
  assign motorDeenergize = st.deenergize;
  assign motorStopNow = st.stopNow;
  assign motorDecelStop = st.decelStop;
  assign programHalt = st.progHalt;
  assign ioAssignRelease = st.ioRelease;
  assign electricalHomeReset = st.homeReset;
  assign softLimitDisable = st.swLimitOff;
  assign irq = st.irq;

  estop_latch_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE1
    !st.almActive && emergencyStopInput && !driverFailure && !nvParamCorrupt && !motorSensorFault &&
    !overcurrentFault && !(shaftTurning && powerUp) && !emergency_stop_action_select
    |=> st.almCode == 8'h68 ##1 st.blinkCnt == 4'h6 && motorDeenergize && programHalt)
    else $error("Emergency stop not latched with six flashes");

  limit_group_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE2
    st.almActive && st.almCode == 8'h60 |-> ##1 st.blinkCnt == 4'h7 || !st.almActive || st.almCode != 8'h60)
    else $error("Limit fault not in seven-flash group");

  sensor_torque_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE8
    $rose(st.almActive) && st.almCode == 8'h42 |-> motorDeenergize && st.blinkCnt == 4'h8 && !st.alarm_clear_command)
    else $error("Sensor fault did not remove torque");

  decel_stop_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE6
    st.almActive && st.almCode == 8'h67 |-> motorDecelStop && !motorStopNow && !motorDeenergize)
    else $error("Software overtravel not decelerating");

  system_steady_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE11
    st.almActive && st.almCode == 8'hF0 |=> st.blinkCnt == 4'hF && motorDeenergize)
    else $error("System failure lamp not steady");

  alarm_out_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE12
    $changed(st.almActive) |-> alarmOutput == !st.almActive && $past(alarmOutput) != alarmOutput)
    else $error("Alarm output not following alarm state");

  locked_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE17
    st.almActive && !st.alarm_clear_command && clearReq |=> st.almActive && $stable(st.almCode))
    else $error("Power-cycle alarm cleared by input or command");

  clear_edge_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE14
    st.almActive && st.alarm_clear_command && st.aclPrev && !alarmClearInput && newCode == 8'h00 |=>
    !st.almActive ##1 (!st.almActive || $past(newCode) != 8'h00))
    else $error("Clearable alarm not cleared");

  clear_init_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE16
    doClear && st.almCode == 8'h21 |=> ioAssignRelease && electricalHomeReset && softLimitDisable ##1 !ioAssignRelease)
    else $error("Overheat clear missed initialisation");

  query_code_a: assert property (@(posedge clk_sys) disable iff (reset) // RULE13
    rdFire && s_axi_araddr == 8'h00 |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(st.almCode))
    else $error("Alarm query returned wrong code");

endmodule

//--- sim/mam_fault_src.sv
// Plant-side fault source: one fault condition at a time
`timescale 1ns/1ns
module mam_fault_src
(
  // Fault selector, zero is healthy
  input  wire logic [4:0] sel,
  // Detector levels toward the block
  output logic [17:0]     flt
);
  // The row loop drops the cause before it clears; the final interrupt test keeps 0Dh selected, so its cleared alarm re-raises
  always_comb
  begin
    flt = '0;
    if (sel == 5'h02)
      flt[2:1] = 2'h3;
    else if (sel != 5'h00)
      flt[sel - 5'h01] = 1'b1;
  end
endmodule

//--- sim/test_motion_alarm_manager.sv
// Self-checking bench for the motion alarm manager
`timescale 1ns/1ns
`include "mam_defines.svh"
module test_motion_alarm_manager;
  typedef struct packed {logic [4:0] sel; logic [7:0] code; logic [3:0] nfl; logic [5:0] f;} mam_row_s;
  logic        clk_sys = 1'b0, reset = 1'b1, alarmClearInput = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        emergency_stop_action_select = 1'b0, emergency_halt_action_select = 1'b1;
  logic        alarmOutput, alarmIndicatorLamp, motorDeenergize, motorStopNow, motorDecelStop, programHalt;
  logic        ioAssignRelease, electricalHomeReset, softLimitDisable, irq;
  logic [4:0]  sel = 5'h00;
  logic [17:0] flt;
  int          fail_count = 0, n_checks = 0, n;
  // Flag bits: clearable, deenergize/stop/decel, clear side effects, stop select
  mam_row_s    rows [18] = '{
    {5'h01, 8'h68, 4'h6, 6'h30}, {5'h01, 8'h68, 4'h7, 6'h29},
    {5'h02, 8'h60, 4'h7, 6'h28}, {5'h04, 8'h61, 4'h7, 6'h28},
    {5'h05, 8'h62, 4'h7, 6'h28}, {5'h06, 8'h66, 4'h7, 6'h28},
    {5'h07, 8'h67, 4'h7, 6'h24}, {5'h08, 8'h70, 4'h7, 6'h28},
    {5'h09, 8'h42, 4'h8, 6'h10}, {5'h0A, 8'h43, 4'h8, 6'h10},
    {5'h0B, 8'h41, 4'h9, 6'h10}, {5'h0C, 8'hF0, 4'h1, 6'h10},
    {5'h0D, 8'h21, 4'h2, 6'h32}, {5'h0E, 8'h30, 4'h2, 6'h32},
    {5'h0F, 8'h31, 4'h2, 6'h32}, {5'h10, 8'h22, 4'h3, 6'h32},
    {5'h11, 8'h10, 4'h4, 6'h32}, {5'h12, 8'h20, 4'h5, 6'h10}};

  always #25 clk_sys = ~clk_sys;

  mam_fault_src src (.sel, .flt);
  motion_alarm_manager #(.BLINK_ON_CYC(4), .BLINK_OFF_CYC(4), .BLINK_GAP_CYC(10)) uut (
    .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .emergencyStopInput(flt[0]), .forwardLimitSensor(flt[1]), .reverseLimitSensor(flt[2]),
    .limitSwapDetected(flt[3]), .homeSeekFailed(flt[4]), .hwLimitPassed(flt[5]), .swLimitPassed(flt[6]),
    .invalidOpStarted(flt[7]), .motorSensorFault(flt[8]), .shaftTurning(flt[9]), .nvParamCorrupt(flt[10]),
    .driverFailure(flt[11]), .overheatFault(flt[12]), .overloadFault(flt[13]), .overspeedFault(flt[14]),
    .overvoltageFault(flt[15]), .deviationFault(flt[16]), .overcurrentFault(flt[17]),
    .emergency_stop_action_select, .emergency_halt_action_select, .alarmClearInput, .alarmOutput,
    .alarmIndicatorLamp, .motorDeenergize, .motorStopNow, .motorDecelStop, .programHalt,
    .ioAssignRelease, .electricalHomeReset, .softLimitDisable, .irq);

  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Eight cycles per flash ends the window before the next sequence's first flash
  task automatic flashes(input int w);
    logic p;
    n = 1;
    while (!alarmIndicatorLamp) @(posedge clk_sys);
    p = 1'b1;
    repeat (w)
    begin
      @(posedge clk_sys);
      if (alarmIndicatorLamp && !p) n++;
      p = alarmIndicatorLamp;
    end
  endtask

  // Reset stands in for a full power cycle
  task automatic rst;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    close_out;
  end

  initial
  begin
    foreach (rows[i])
    begin
      emergency_stop_action_select <= rows[i].f[0];
      rst;
      sel <= rows[i].sel;
      repeat (2) @(posedge clk_sys);
      chkv(alarmOutput, 0);
      chkv({motorDeenergize, motorStopNow, motorDecelStop}, rows[i].f[4:2]);
      chkv(programHalt, (rows[i].code == 8'h68 && !rows[i].f[0]) || rows[i].code == 8'h66 || rows[i].f[1]);
      axr(`MAM_REG_ALARM);
      chkv(rd, {22'h0, rows[i].f[5], 1'b1, rows[i].code});
      flashes(8 * rows[i].nfl);
      chkv(n, rows[i].nfl);
      if (rows[i].code == 8'hF0) chkv(alarmIndicatorLamp, 1);
      sel <= 5'h00;
      if (i % 2)
        axw(`MAM_REG_CLEAR, 32'h1);
      else
      begin
        alarmClearInput <= 1'b1;
        @(posedge clk_sys);
        alarmClearInput <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      chkv(alarmOutput, rows[i].f[5]);
      chkv({electricalHomeReset, softLimitDisable}, {2{rows[i].f[1]}});
      $display("row %0d code %0h done", i, rows[i].code);
    end
    rst;
    @(posedge clk_sys);
    chkv({alarmOutput, alarmIndicatorLamp, irq}, 3'h4);
    axr(8'h10);
    chkv(rsp, `MAM_RESP_SLVERR);
    chkv(rd, 0);
    axw(`MAM_REG_INT_MASK, 32'h1);
    sel <= 5'h0D;
    repeat (4) @(posedge clk_sys);
    chkv(irq, 1);
    alarmClearInput <= 1'b1;
    @(posedge clk_sys);
    alarmClearInput <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chkv(ioAssignRelease, 1);
    @(posedge clk_sys);
    chkv(alarmOutput, 0);
    axr(`MAM_REG_INT_STATUS);
    chkv(rd[1:0], 2'h3);
    repeat (2) @(posedge clk_sys);
    chkv(irq, 0);
    $display("register and interrupt tests done");
    close_out;
  end
endmodule
